/* src/dbgm_cfg.svh */
// What this block does
// - Segment select 1 sends debug loads/stores in register range to system memory
// - Status bits 27, 26, 24, 23..18 read zero and ignore writes
// - Count-in-debug reads 0; cycle counter stopped while in debug mode
// - Exception code 14:10 records latest debug-mode cause; code 30 is cache error
// - Bit 8 read/write single-step enable, resets to 0
// - Bit 5 flags debug interrupt; cleared by exception in debug mode
// - Bit 1 flags breakpoint instruction; cleared by exception in debug mode
// - Bit 0 flags single step; cleared by exception in debug mode
// - Return pc loads on every debug exception and debug-mode exception
// - Precise: faulting pc, or branch pc with delay-slot flag set
// - Imprecise: return pc holds resume address
// - 32-bit scratch register with no side effects
// - Debug-mode accesses from 0xff200000 to segment top bypass translation
// - Segment split: probe region 0xff20_0000, register region 0xff30_0000 up
// - Physical address bits 35:32 are zero in the debug segment
// - Probe serves all fetches in probe region, data when segment select 0
// - Register region accessible only with segment select 0
// - Debug control 0x0000, break status 0x000c, break set 0x0300..0x0314
// - Control bit 29 shows endian mode, 1 big-endian, resets to 1
// - Control bits 17 and 16 read zero
// - Control bits 4, 3, 1 read 1; bit 2 reads 0
// - Control bit 0 mirrors probe enable of test port control
// - Segment select 0 routes debug loads/stores in register range to registers
// - Debug mode flag bit 30 is 1 in debug mode, resets to 0
`ifndef DBGM_CFG_SVH
`define DBGM_CFG_SVH
`define DBGM_SEG_PROBE      12'hff2
`define DBGM_SEG_REGS       12'hff3
`define DBGM_OFF_CTRL       20'h00000
`define DBGM_OFF_BSTAT      20'h0000c
`define DBGM_OFF_BADDR_LO   20'h00300
`define DBGM_OFF_BDATA      20'h00304
`define DBGM_OFF_BDMASK     20'h00308
`define DBGM_OFF_BCTRL      20'h0030c
`define DBGM_OFF_BADDR_HI   20'h00310
`define DBGM_OFF_BHMASK     20'h00314
`define DBGM_ST_DD          31
`define DBGM_ST_DM          30
`define DBGM_ST_SEGSEL      28
`define DBGM_ST_VER_LO      15
`define DBGM_ST_CODE_HI     14
`define DBGM_ST_CODE_LO     10
`define DBGM_ST_SS          8
`define DBGM_ST_DI          5
`define DBGM_ST_DB          1
`define DBGM_ST_DS          0
`define DBGM_ST_WMASK       32'h1000_0100
`define DBGM_CTRL_CONST     32'h0000_001a
`define DBGM_CTRL_EN        29
`define DBGM_CODE_CACHE_ERROR_CODE  5'h1e
`define DBGM_BCTRL_WMASK    32'hffff_ffc9
`define DBGM_BHI_WMASK      32'h0000_000f
`endif

/* src/dbgm_pkg.sv */
package dbgm_pkg;
    typedef enum logic [2:0]
    {
        DBGM_EXC_STEP  = 3'b001,
        DBGM_EXC_BREAK = 3'b010,
        DBGM_EXC_INTR  = 3'b100
    } dbgm_exc_t;
    typedef enum logic [1:0]
    {
        DBGM_RT_NORMAL = 2'b00,
        DBGM_RT_PROBE  = 2'b01,
        DBGM_RT_REGS   = 2'b10,
        DBGM_RT_SYSMEM = 2'b11
    } dbgm_route_t;
endpackage

/* src/dbgm_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dbgm_cfg.svh"
module dbgm_decode
(
    input  wire logic                  in_debug,
    input  wire logic                  seg_select,
    input  wire logic                  is_fetch,
    input  wire logic [31:0]           vaddr,
    output dbgm_pkg::dbgm_route_t      route,
    output logic                       bypass
);
    import dbgm_pkg::*;
    logic in_probe;
    logic in_regs;
    assign in_probe = vaddr[31:20] == `DBGM_SEG_PROBE;
    assign in_regs  = vaddr[31:20] == `DBGM_SEG_REGS;
    assign bypass   = in_debug && (in_probe || in_regs);
    always_comb
    begin
        route = DBGM_RT_NORMAL;
        if (in_debug && in_probe && (is_fetch || !seg_select))
            route = DBGM_RT_PROBE;
        else if (in_debug && in_regs && !is_fetch)
            route = seg_select ? DBGM_RT_SYSMEM : DBGM_RT_REGS;
    end
endmodule
`default_nettype wire

/* src/dbgm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dbgm_cfg.svh"
module dbgm_top
(
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // Coprocessor register port
    input  wire logic                  cp_wr,
    input  wire logic [1:0]            cp_sel,
    input  wire logic [31:0]           cp_wdata,
    output logic      [31:0]           cp_rdata_q,
    // Exception events from the pipeline
    input  wire logic                  dbg_exc,
    input  wire dbgm_pkg::dbgm_exc_t   dbg_exc_kind,
    input  wire logic                  norm_exc,
    input  wire logic [4:0]            norm_exc_code,
    input  wire logic                  exc_precise,
    input  wire logic                  exc_in_slot,
    input  wire logic [31:0]           exc_pc,
    input  wire logic [31:0]           branch_pc,
    input  wire logic [31:0]           resume_pc,
    input  wire logic                  debug_return,
    input  wire logic                  big_endian,
    input  wire logic                  probe_enable,
    input  wire logic                  bus_break_hit,
    // Memory access decode
    input  wire logic                  acc_valid,
    input  wire logic                  acc_fetch,
    input  wire logic                  acc_write,
    input  wire logic [31:0]           acc_vaddr,
    input  wire logic [31:0]           acc_wdata,
    output dbgm_pkg::dbgm_route_t      acc_route_q,
    output logic                       acc_bypass_q,
    output logic      [3:0]            acc_paddr_hi_q,
    output logic      [31:0]           acc_rdata_q,
    output logic                       step_enable_q,
    output logic                       count_stop_q,
    output logic                       debug_mode_q
);
    import dbgm_pkg::*;

    logic        delay_slot_q;
    logic        seg_select_q;
    logic [4:0]  exc_code_q;
    logic        flag_intr_q;
    logic        flag_brk_q;
    logic        flag_step_q;
    logic [31:0] return_pc_q;
    logic [31:0] scratch_q;
    logic        endian_q;
    logic        bstat_q;
    logic [31:0] baddr_lo_q;
    logic [31:0] bdata_q;
    logic [31:0] bdmask_q;
    logic [31:0] bctrl_q;
    logic [31:0] baddr_hi_q;
    logic [31:0] bhmask_q;
    logic [2:0]  probe_sync_q;
    logic        probe_en_q;
    logic [31:0] status_w;
    logic [31:0] ctrl_w;
    logic        any_exc;
    logic        exc_in_dbg;
    dbgm_route_t route_w;
    logic        bypass_w;
    logic        reg_wr;
    logic [19:0] reg_off;

    assign any_exc    = dbg_exc || (norm_exc && debug_mode_q);
    assign exc_in_dbg = norm_exc && debug_mode_q;
    assign reg_off    = acc_vaddr[19:0];
    assign reg_wr     = acc_valid && acc_write && route_w == DBGM_RT_REGS;

    dbgm_decode dbgm_decode_inst
    (
        .in_debug   (debug_mode_q),
        .seg_select (seg_select_q),
        .is_fetch   (acc_fetch),
        .vaddr      (acc_vaddr),
        .route      (route_w),
        .bypass     (bypass_w)
    );

    function automatic logic [31:0] reg_read(input logic [19:0] off);
        unique case (off)
            `DBGM_OFF_CTRL:     reg_read = ctrl_w;
            `DBGM_OFF_BSTAT:    reg_read = {31'h0, bstat_q};
            `DBGM_OFF_BADDR_LO: reg_read = baddr_lo_q;
            `DBGM_OFF_BDATA:    reg_read = bdata_q;
            `DBGM_OFF_BDMASK:   reg_read = bdmask_q;
            `DBGM_OFF_BCTRL:    reg_read = bctrl_q;
            `DBGM_OFF_BADDR_HI: reg_read = baddr_hi_q;
            `DBGM_OFF_BHMASK:   reg_read = bhmask_q;
            default:            reg_read = 32'h0;
        endcase
    endfunction

    // Status word; unlisted bits read zero
    always_comb
    begin
        status_w = 32'h0;
        status_w[`DBGM_ST_DD] = delay_slot_q;
        status_w[`DBGM_ST_DM] = debug_mode_q;
        status_w[`DBGM_ST_SEGSEL] = seg_select_q;
        status_w[`DBGM_ST_VER_LO] = 1'b1;
        status_w[`DBGM_ST_CODE_HI:`DBGM_ST_CODE_LO] = exc_code_q;
        status_w[`DBGM_ST_SS] = step_enable_q;
        status_w[`DBGM_ST_DI] = flag_intr_q;
        status_w[`DBGM_ST_DB] = flag_brk_q;
        status_w[`DBGM_ST_DS] = flag_step_q;
    end

    always_comb
    begin
        ctrl_w = `DBGM_CTRL_CONST;
        ctrl_w[`DBGM_CTRL_EN] = endian_q;
        ctrl_w[0] = probe_en_q;
    end

    // Probe enable from outside, three-stage sampled
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            probe_sync_q <= 3'h0;
            probe_en_q   <= 1'b0;
        end
        else
        begin
            probe_sync_q <= {probe_sync_q[1:0], probe_enable};
            if (probe_sync_q[1] == probe_sync_q[2])
                probe_en_q <= probe_sync_q[2];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            endian_q <= 1'b1;
        else
            endian_q <= big_endian;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            debug_mode_q <= 1'b0;
        else if (dbg_exc)
            debug_mode_q <= 1'b1;
        else if (debug_return)
            debug_mode_q <= 1'b0;
    end

    // Writable status fields; read-only parts ignore writes
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            step_enable_q <= 1'b0;
            seg_select_q  <= 1'b0;
        end
        else if (cp_wr && cp_sel == 2'h0)
        begin
            step_enable_q <= cp_wdata[`DBGM_ST_SS];
            seg_select_q  <= cp_wdata[`DBGM_ST_SEGSEL];
        end
    end

    // Cause flags: a fresh exception clears, a debug exception sets its kind
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            flag_intr_q  <= 1'b0;
            flag_brk_q   <= 1'b0;
            flag_step_q  <= 1'b0;
            delay_slot_q <= 1'b0;
            exc_code_q   <= 5'h0;
        end
        else if (any_exc)
        begin
            flag_intr_q  <= dbg_exc && dbg_exc_kind == DBGM_EXC_INTR;
            flag_brk_q   <= dbg_exc && dbg_exc_kind == DBGM_EXC_BREAK;
            flag_step_q  <= dbg_exc && dbg_exc_kind == DBGM_EXC_STEP;
            delay_slot_q <= exc_precise && exc_in_slot;
            if (exc_in_dbg)
                exc_code_q <= norm_exc_code;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            return_pc_q <= 32'h0;
        else if (any_exc)
        begin
            if (!exc_precise)
                return_pc_q <= resume_pc;
            else if (exc_in_slot)
                return_pc_q <= branch_pc;
            else
                return_pc_q <= exc_pc;
        end
        else if (cp_wr && cp_sel == 2'h1)
            return_pc_q <= cp_wdata;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            scratch_q <= 32'h0;
        else if (cp_wr && cp_sel == 2'h2)
            scratch_q <= cp_wdata;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            cp_rdata_q <= 32'h0;
        else
            unique case (cp_sel)
                2'h0:    cp_rdata_q <= status_w;
                2'h1:    cp_rdata_q <= return_pc_q;
                2'h2:    cp_rdata_q <= scratch_q;
                default: cp_rdata_q <= 32'h0;
            endcase
    end

    // Break status: hit sets, writing 0 clears, set wins
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            bstat_q <= 1'b0;
        else if (bus_break_hit)
            bstat_q <= 1'b1;
        else if (reg_wr && reg_off == `DBGM_OFF_BSTAT && !acc_wdata[0])
            bstat_q <= 1'b0;
    end

    // Break register set; address low and data are read-only
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            baddr_lo_q <= 32'h0;
            bdata_q    <= 32'h0;
            bdmask_q   <= 32'h0;
            bctrl_q    <= 32'h0;
            baddr_hi_q <= 32'h0;
            bhmask_q   <= 32'h0;
        end
        else if (reg_wr)
        begin
            if (reg_off == `DBGM_OFF_BDMASK)
                bdmask_q <= acc_wdata;
            if (reg_off == `DBGM_OFF_BCTRL)
                bctrl_q <= acc_wdata & `DBGM_BCTRL_WMASK;
            if (reg_off == `DBGM_OFF_BADDR_HI)
                baddr_hi_q <= acc_wdata & `DBGM_BHI_WMASK;
            if (reg_off == `DBGM_OFF_BHMASK)
                bhmask_q <= acc_wdata & `DBGM_BHI_WMASK;
        end
    end

    // Registered access decode and register read data
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            acc_route_q    <= DBGM_RT_NORMAL;
            acc_bypass_q   <= 1'b0;
            acc_paddr_hi_q <= 4'h0;
            acc_rdata_q    <= 32'h0;
        end
        else
        begin
            acc_route_q  <= acc_valid ? route_w : DBGM_RT_NORMAL;
            acc_bypass_q <= acc_valid && bypass_w;
            acc_paddr_hi_q <= bypass_w ? 4'h0 : baddr_hi_q[3:0];
            if (acc_valid && route_w == DBGM_RT_REGS)
                acc_rdata_q <= reg_read(reg_off);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            count_stop_q <= 1'b0;
        else
            count_stop_q <= dbg_exc || (debug_mode_q && !debug_return);
    end

    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence exc_taken_s;
        any_exc;
    endsequence

    // Debug-mode data access into the register half
    sequence regs_data_s;
        acc_valid && debug_mode_q && !acc_fetch && acc_vaddr[31:20] == `DBGM_SEG_REGS;
    endsequence

    status_zero_a: assert property ((status_w & 32'h0ffc_0000) == 32'h0)
        else $error("unimplemented status bits nonzero");
    count_stop_a: assert property (count_stop_q == debug_mode_q)
        else $error("counter stop differs from debug mode");
    code_load_a: assert property (exc_in_dbg |=> exc_code_q == $past(norm_exc_code))
        else $error("exception code not captured");
    step_hold_a: assert property (!(cp_wr && cp_sel == 2'h0) |=> $stable(step_enable_q))
        else $error("step enable changed without write");
    intr_flag_a: assert property (exc_taken_s ##1 1 |->
        flag_intr_q == $past(dbg_exc && dbg_exc_kind == DBGM_EXC_INTR))
        else $error("interrupt flag wrong");
    brk_clr_a: assert property (exc_in_dbg && !dbg_exc |=> !flag_brk_q && !flag_step_q)
        else $error("flags not cleared");
    pc_slot_a: assert property (any_exc && exc_precise && exc_in_slot |=>
        return_pc_q == $past(branch_pc) && delay_slot_q)
        else $error("delay slot pc wrong");
    pc_impr_a: assert property (any_exc && !exc_precise |=> return_pc_q == $past(resume_pc))
        else $error("imprecise pc wrong");
    scratch_keep_a: assert property (!(cp_wr && cp_sel == 2'h2) |=> $stable(scratch_q))
        else $error("scratch changed");
    paddr_zero_a: assert property (acc_valid && bypass_w |=>
        acc_paddr_hi_q == 4'h0 && acc_bypass_q)
        else $error("debug segment not bypassed");
    regs_gate_a: assert property (acc_route_q == DBGM_RT_REGS |-> !$past(seg_select_q))
        else $error("register region with select set");
    ctrl_const_a: assert property (ctrl_w[4:1] == 4'hd && ctrl_w[17:16] == 2'h0)
        else $error("control constants wrong");
    pc_exact_a: assert property (any_exc && exc_precise && !exc_in_slot |=>
        return_pc_q == $past(exc_pc) && !delay_slot_q)
        else $error("faulting pc wrong");
    mode_enter_a: assert property (dbg_exc |=> debug_mode_q && count_stop_q)
        else $error("debug mode not entered");
    mode_leave_a: assert property (debug_return && !dbg_exc |=> !debug_mode_q)
        else $error("debug mode not left");
    endian_track_a: assert property (1'b1 |=> endian_q == $past(big_endian))
        else $error("endian mode not tracked");
    sysmem_route_a: assert property (regs_data_s ##0 seg_select_q |=> acc_route_q == DBGM_RT_SYSMEM)
        else $error("register range not sent to memory");
    regs_route_a: assert property (regs_data_s ##0 !seg_select_q |=> acc_route_q == DBGM_RT_REGS)
        else $error("register range not sent to registers");
    probe_fetch_a: assert property (acc_valid && debug_mode_q && acc_fetch &&
        acc_vaddr[31:20] == `DBGM_SEG_PROBE |=> acc_route_q == DBGM_RT_PROBE)
        else $error("probe fetch not routed to probe");
    bstat_set_a: assert property (bus_break_hit |=> bstat_q)
        else $error("break status not set");
    scratch_load_a: assert property (cp_wr && cp_sel == 2'h2 |=> scratch_q == $past(cp_wdata))
        else $error("scratch not written");
    probe_mirror_a: assert property (probe_sync_q[1] == probe_sync_q[2] |=>
        probe_en_q == $past(probe_sync_q[2]))
        else $error("probe enable not taken");
endmodule
`default_nettype wire

/* verif/dbgm_probe_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dbgm_probe_model
(
    input  wire logic       core_clk,
    input  wire logic       want_on,
    input  wire logic [1:0] route,
    output logic            probe_enable,
    output logic [7:0]      served
);
    initial served = 8'h00;
    initial probe_enable = 1'b0;
    // Enable moves off the core clock edge
    always @(want_on) probe_enable <= #7 want_on;
    always @(posedge core_clk)
        if (probe_enable && route == 2'h1) served <= served + 8'h01;
endmodule
`default_nettype wire

/* verif/debug_mode_register_set_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module debug_mode_register_set_tb;
    import dbgm_pkg::*;
    logic        core_clk, reset_n, cp_wr, dbg_exc, norm_exc, exc_precise, exc_in_slot;
    logic        debug_return, big_endian, bus_break_hit, acc_valid, acc_fetch, acc_write;
    logic        want_on, probe_enable, acc_bypass_q, step_enable_q, count_stop_q, debug_mode_q;
    logic [1:0]  cp_sel;
    logic [4:0]  norm_exc_code;
    logic [3:0]  acc_paddr_hi_q;
    logic [7:0]  served;
    logic [31:0] cp_wdata, cp_rdata_q, exc_pc, branch_pc, resume_pc;
    logic [31:0] acc_vaddr, acc_wdata, acc_rdata_q, rd;
    dbgm_exc_t   dbg_exc_kind;
    dbgm_route_t acc_route_q;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    dbgm_top dbgm_top_inst
    (
        .core_clk, .reset_n, .cp_wr, .cp_sel, .cp_wdata, .cp_rdata_q, .dbg_exc,
        .dbg_exc_kind, .norm_exc, .norm_exc_code, .exc_precise, .exc_in_slot, .exc_pc,
        .branch_pc, .resume_pc, .debug_return, .big_endian, .probe_enable, .bus_break_hit,
        .acc_valid, .acc_fetch, .acc_write, .acc_vaddr, .acc_wdata, .acc_route_q,
        .acc_bypass_q, .acc_paddr_hi_q, .acc_rdata_q, .step_enable_q, .count_stop_q,
        .debug_mode_q
    );

    dbgm_probe_model dbgm_probe_model_inst
    (
        .core_clk, .want_on, .route(acc_route_q), .probe_enable, .served
    );

    task automatic report_and_stop();
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, msk);
        checked++;
        if ((got & msk) !== (exp & msk))
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h mask %h", $time, got, exp, msk);
        end
    endtask

    task automatic cp_wr_t(input logic [1:0] s, input logic [31:0] d);
        @(negedge core_clk);
        cp_sel = s;
        cp_wdata = d;
        cp_wr = 1'b1;
        @(negedge core_clk);
        cp_wr = 1'b0;
    endtask

    task automatic cp_rd(input logic [1:0] s);
        @(negedge core_clk);
        cp_sel = s;
        @(negedge core_clk);
        rd = cp_rdata_q;
    endtask

    task automatic exc(input logic d, input dbgm_exc_t k, input logic [4:0] c,
                       input logic p, sl);
        @(negedge core_clk);
        dbg_exc = d;
        norm_exc = ~d;
        dbg_exc_kind = k;
        norm_exc_code = c;
        exc_precise = p;
        exc_in_slot = sl;
        @(negedge core_clk);
        dbg_exc = 1'b0;
        norm_exc = 1'b0;
    endtask

    task automatic dret();
        @(negedge core_clk);
        debug_return = 1'b1;
        @(negedge core_clk);
        debug_return = 1'b0;
    endtask

    task automatic acc(input logic f, w, input logic [31:0] a, d);
        @(negedge core_clk);
        acc_valid = 1'b1;
        acc_fetch = f;
        acc_write = w;
        acc_vaddr = a;
        acc_wdata = d;
        @(negedge core_clk);
        acc_valid = 1'b0;
    endtask

    task automatic acc_chk(input dbgm_route_t r, input logic b, input logic [3:0] h);
        chk({acc_paddr_hi_q, acc_bypass_q, acc_route_q}, {h, b, r}, 32'h7f);
    endtask

    task automatic t_status();
        cp_rd(2'h0);
        chk(rd, 32'h0, 32'h4ffc_0100);
        cp_wr_t(2'h0, 32'hffff_ffff);
        chk({debug_mode_q, step_enable_q}, 32'h1, 32'h3);
        cp_rd(2'h0);
        chk(rd, 32'h1000_0100, 32'h5ffc_0100);
        cp_wr_t(2'h0, 32'h0);
        chk(step_enable_q, 32'h0, 32'h1);
    endtask

    task automatic t_scratch();
        cp_wr_t(2'h2, 32'ha5c3_0f96);
        cp_wr_t(2'h1, 32'h1234_5678);
        cp_rd(2'h2);
        chk(rd, 32'ha5c3_0f96, 32'hffff_ffff);
        exc(1'b0, DBGM_EXC_STEP, 5'h1e, 1'b1, 1'b0);
        cp_rd(2'h1);
        chk(rd, 32'h1234_5678, 32'hffff_ffff);
        chk(debug_mode_q, 32'h0, 32'h1);
    endtask

    task automatic t_dbg_exc();
        dbgm_exc_t k [3] = '{DBGM_EXC_STEP, DBGM_EXC_BREAK, DBGM_EXC_INTR};
        logic [31:0] f [3] = '{32'h1, 32'h2, 32'h20};
        for (int i = 0; i < 3; i++)
        begin
            exc(1'b1, k[i], 5'h00, 1'b1, i == 1);
            chk({debug_mode_q, count_stop_q}, 32'h3, 32'h3);
            cp_rd(2'h0);
            chk(rd, {i == 1, 31'h4000_0000} | f[i], 32'hc000_0023);
            cp_rd(2'h1);
            chk(rd, i == 1 ? branch_pc : exc_pc, 32'hffff_ffff);
            dret();
            chk({debug_mode_q, count_stop_q}, 32'h0, 32'h3);
        end
    endtask

    task automatic t_norm_exc();
        exc(1'b1, DBGM_EXC_BREAK, 5'h00, 1'b1, 1'b0);
        exc(1'b0, DBGM_EXC_STEP, 5'h1e, 1'b1, 1'b1);
        cp_rd(2'h0);
        chk(rd, 32'hc000_7800, 32'hc000_7c23);
        cp_rd(2'h1);
        chk(rd, branch_pc, 32'hffff_ffff);
        exc(1'b0, DBGM_EXC_STEP, 5'h04, 1'b0, 1'b1);
        cp_rd(2'h0);
        chk(rd, 32'h4000_1000, 32'h4000_7c00);
        cp_rd(2'h1);
        chk(rd, resume_pc, 32'hffff_ffff);
    endtask

    task automatic t_access();
        want_on = 1'b1;
        repeat (6) @(negedge core_clk);
        bus_break_hit = 1'b1;
        @(negedge core_clk);
        bus_break_hit = 1'b0;
        acc(1'b0, 1'b0, 32'hff30_000c, 32'h0);
        acc_chk(DBGM_RT_REGS, 1'b1, 4'h0);
        chk(acc_rdata_q, 32'h1, 32'h1);
        acc(1'b0, 1'b1, 32'hff30_000c, 32'h0);
        acc(1'b0, 1'b0, 32'hff30_000c, 32'h0);
        chk(acc_rdata_q, 32'h0, 32'h1);
        acc(1'b0, 1'b0, 32'hff30_0000, 32'h0);
        chk(acc_rdata_q, 32'h2000_001b, 32'hffff_ffff);
        big_endian = 1'b0;
        acc(1'b0, 1'b1, 32'hff30_0000, 32'hffff_ffff);
        acc(1'b0, 1'b0, 32'hff30_0000, 32'h0);
        chk(acc_rdata_q, 32'h0000_001b, 32'hffff_ffff);
        acc(1'b0, 1'b1, 32'hff30_0308, 32'h5a5a_0ff0);
        acc(1'b0, 1'b1, 32'hff30_0300, 32'hffff_ffff);
        acc(1'b0, 1'b0, 32'hff30_0308, 32'h0);
        chk(acc_rdata_q, 32'h5a5a_0ff0, 32'hffff_ffff);
        acc(1'b0, 1'b0, 32'hff30_0300, 32'h0);
        chk(acc_rdata_q, 32'h0, 32'hffff_ffff);
        acc(1'b0, 1'b1, 32'hff30_0310, 32'h5);
        acc(1'b1, 1'b0, 32'hff2f_fffc, 32'h0);
        acc_chk(DBGM_RT_PROBE, 1'b1, 4'h0);
        acc(1'b0, 1'b0, 32'hff20_0010, 32'h0);
        acc_chk(DBGM_RT_PROBE, 1'b1, 4'h0);
        acc(1'b0, 1'b0, 32'hff1f_fffc, 32'h0);
        acc_chk(DBGM_RT_NORMAL, 1'b0, 4'h5);
        chk(served != 8'h00, 32'h1, 32'h1);
        cp_wr_t(2'h0, 32'h1000_0000);
        acc(1'b0, 1'b0, 32'hff30_000c, 32'h0);
        acc_chk(DBGM_RT_SYSMEM, 1'b1, 4'h0);
        acc(1'b0, 1'b0, 32'hff20_0000, 32'h0);
        acc_chk(DBGM_RT_NORMAL, 1'b1, 4'h0);
        cp_wr_t(2'h0, 32'h0);
        dret();
        acc(1'b0, 1'b0, 32'hff30_000c, 32'h0);
        chk({acc_bypass_q, acc_route_q}, 32'h0, 32'h7);
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    initial
    begin
        reset_n = 1'b0;
        {cp_wr, dbg_exc, norm_exc, exc_precise, exc_in_slot, debug_return} = '0;
        {bus_break_hit, acc_valid, acc_fetch, acc_write, want_on} = '0;
        {cp_sel, cp_wdata, norm_exc_code, acc_vaddr, acc_wdata} = '0;
        big_endian = 1'b1;
        dbg_exc_kind = DBGM_EXC_STEP;
        exc_pc = 32'h8000_0100;
        branch_pc = 32'h8000_00fc;
        resume_pc = 32'h8000_0200;
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        t_status();
        t_scratch();
        t_dbg_exc();
        t_norm_exc();
        t_access();
        report_and_stop();
    end
endmodule
`default_nettype wire
